// [design/pwt_consts.vh]
// register offsets, field positions and reset values of the pwm timer
`ifndef PWT_CONSTS_VH
`define PWT_CONSTS_VH
// ****************************
// register offsets
// ****************************
`define PWT_CTRLA 8'h00
`define PWT_CTRLC 8'h02
`define PWT_CTRLD 8'h03
`define PWT_CMD_CTRL 8'h04
`define PWT_EVENT_INPUT_CONTROL_A 8'h08
`define PWT_EVENT_INPUT_CONTROL_B 8'h09
`define PWT_INT_EN 8'h0C
`define PWT_INT_FLAG 8'h0D
`define PWT_STATUS 8'h0E
`define PWT_INMODE_A 8'h10
`define PWT_INMODE_B 8'h11
`define PWT_FAULT_CTRL 8'h12
`define PWT_DLYCTRL 8'h14
`define PWT_DELAY_COUNT_VALUE 8'h15
`define PWT_DITCTRL 8'h18
`define PWT_DITVAL 8'h19
`define PWT_SNAP_A_L 8'h22
`define PWT_SNAP_A_H 8'h23
`define PWT_SNAP_B_L 8'h24
`define PWT_SNAP_B_H 8'h25
`define PWT_ASET_L 8'h28
`define PWT_ACLR_L 8'h2A
`define PWT_BSET_L 8'h2C
`define PWT_BCLR_L 8'h2E
`define PWT_PROTECT_KEY 8'h3F
// ****************************
// field positions
// ****************************
`define PWT_ENABLE_BIT 0
`define PWT_OVR_BIT 0
`define PWT_CSEL_BIT 6
`define PWT_DSEL_BIT 7
`define PWT_SCAP_A_BIT 3
`define PWT_SCAP_B_BIT 4
`define PWT_ACTION_BIT 2
`define PWT_IRQ_OVF_BIT 0
`define PWT_IRQ_ON_TIME_A_ENTRY_FLAG_BIT 2
`define PWT_IRQ_ON_TIME_B_ENTRY_FLAG_BIT 3
`define PWT_COMMAND_READY_FLAG_BIT 1
`define PWT_ENRDY_BIT 0
// ****************************
// codes, reset values and timing
// ****************************
`define PWT_MODE_END_ON 4'h8
`define PWT_DELAY_TRIGGER_SELECT_BLANK 2'h1
`define PWT_DELAY_TRIGGER_SELECT_DELAY 2'h2
`define PWT_DITSEL_OTB 2'h0
`define PWT_DITSEL_DTB 2'h2
`define PWT_SLEEP_IDLE 2'h1
`define PWT_RESET_BYTE 8'h00
`define PWT_RESET_CMP 12'h000
// arbitrary unlock key value
`define PWT_UNLOCK_KEY 8'h5A
`define PWT_UNLOCK_CYCLES 3'h4
`endif

// [design/pwt_timer.v]
// one-ramp pwm timer with capture, output routing and output events
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "pwt_consts.vh"
module pwt_timer (
  input wire clock_i,
  input wire rst_i,
  input wire por_i,
  input wire [7:0] timer_output_fuse_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire event_a_i,
  input wire event_b_i,
  input wire fault_i,
  input wire [1:0] sleep_mode_i,
  input wire sleep_i,
  output reg waveform_out_a_o,
  output reg waveform_out_b_o,
  output reg waveform_out_c_o,
  output reg waveform_out_d_o,
  output reg [3:0] output_enable_bits_o,
  output reg evt_b_clear_o,
  output reg evt_a_set_o,
  output reg evt_b_set_o,
  output reg evt_prog_o,
  output wire cycle_end_irq_o,
  output wire on_time_entry_vector_o
);
  localparam [1:0] PH_DTA = 2'h0;
  localparam [1:0] PH_OTA = 2'h1;
  localparam [1:0] PH_DTB = 2'h2;
  localparam [1:0] PH_OTB = 2'h3;
  reg [7:0] ctrla_r, ctrlc_r, ctrld_r, event_input_control_a_r, event_input_control_b_r, int_en_r, flags_r;
  reg [7:0] inmode_a_r, inmode_b_r, fault_ctrl_r, dlyctrl_r, delay_count_value_r, ditctrl_r, ditval_r;
  reg [11:0] aset_r, aclr_r, bset_r, bclr_r, cnt_r, cnt_nxt, snap_a_r, snap_b_r;
  reg [3:0] temp_hi_r;
  reg [1:0] scap_pend_r;
  reg [2:0] unlock_r;
  reg [4:0] dit_acc_r;
  reg dit_ext_r;
  reg [1:0] phase_r;
  reg [1:0] phase_nxt;
  reg [2:0] pre_cnt_r;
  reg [7:0] dly_cnt_r;
  reg dly_busy_r;
  reg [7:0] flags_nxt;
  reg [7:0] rd_nxt;
  reg cycle_end;
  wire running;
  wire cap_a;
  wire cap_b;
  wire wr_fault_ok;
  wire [11:0] bset_eff;
  wire [11:0] bclr_eff;
  wire end_on_a;
  wire end_on_b;
  wire prog_on_time_entry_vector;
  wire dly_tick;
  // ****************************
  // helpers
  // ****************************
  function [1:0] phase_of;
    input [11:0] c;
    input [11:0] as;
    input [11:0] ac;
    input [11:0] bs;
    begin
      if (c < as) begin
        phase_of = PH_DTA;
      end else if (c < ac) begin
        phase_of = PH_OTA;
      end else if (c < bs) begin
        phase_of = PH_DTB;
      end else begin
        phase_of = PH_OTB;
      end
    end
  endfunction
  function [11:0] wr_byte;
    input [11:0] old;
    input hi;
    input [7:0] d;
    begin
      wr_byte = hi ? {d[3:0], old[7:0]} : {old[11:8], d};
    end
  endfunction
  // ****************************
  // counter, phases and dither
  // ****************************
  assign running = ctrla_r[`PWT_ENABLE_BIT] && (!sleep_i || sleep_mode_i == `PWT_SLEEP_IDLE);
  assign bset_eff = (ditctrl_r[1:0] == `PWT_DITSEL_DTB && dit_ext_r) ? bset_r + 12'h001 : bset_r;
  assign bclr_eff = (ditctrl_r[1:0] == `PWT_DITSEL_OTB && dit_ext_r) ? bclr_r + 12'h001 : bclr_r;
  assign end_on_a = event_a_i && inmode_a_r[3:0] == `PWT_MODE_END_ON && phase_r == PH_OTA;
  assign end_on_b = event_b_i && inmode_b_r[3:0] == `PWT_MODE_END_ON && phase_r == PH_OTB;
  always @* begin
    cycle_end = 1'b0;
    cnt_nxt = cnt_r;
    if (running) begin
      if (end_on_b || cnt_r >= bclr_eff) begin
        cycle_end = 1'b1;
        cnt_nxt = 12'h000;
      end else if (end_on_a) begin
        cnt_nxt = aclr_r;
      end else begin
        cnt_nxt = cnt_r + 12'h001;
      end
    end
    phase_nxt = phase_of(cnt_nxt, aset_r, aclr_r, bset_eff);
  end
  always @(posedge clock_i) begin
    if (rst_i) begin
      cnt_r <= `PWT_RESET_CMP;
      phase_r <= PH_DTA;
      dit_acc_r <= 5'h00;
      dit_ext_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
      if (cycle_end) begin
        dit_acc_r <= {1'b0, dit_acc_r[3:0]} + {1'b0, ditval_r[3:0]};
        dit_ext_r <= dit_acc_r[4];
      end
    end
  end
  // ****************************
  // snapshots and flags
  // ****************************
  assign cap_a = (event_a_i && event_input_control_a_r[`PWT_ACTION_BIT]) || scap_pend_r[0];
  assign cap_b = (event_b_i && event_input_control_b_r[`PWT_ACTION_BIT]) || scap_pend_r[1];
  always @* begin
    flags_nxt = flags_r;
    if (wr_i && addr_i == `PWT_INT_FLAG) begin
      flags_nxt = flags_r & ~wdata_i;
    end
    if (cycle_end) begin
      flags_nxt[`PWT_IRQ_OVF_BIT] = 1'b1;
    end
    if (cap_a || (running && phase_nxt == PH_OTA && phase_r != PH_OTA)) begin
      flags_nxt[`PWT_IRQ_ON_TIME_A_ENTRY_FLAG_BIT] = 1'b1;
    end
    if (cap_b || (running && phase_nxt == PH_OTB && phase_r != PH_OTB)) begin
      flags_nxt[`PWT_IRQ_ON_TIME_B_ENTRY_FLAG_BIT] = 1'b1;
    end
  end
  assign cycle_end_irq_o = flags_r[`PWT_IRQ_OVF_BIT] & int_en_r[`PWT_IRQ_OVF_BIT];
  assign on_time_entry_vector_o = (flags_r[`PWT_IRQ_ON_TIME_A_ENTRY_FLAG_BIT] & int_en_r[`PWT_IRQ_ON_TIME_A_ENTRY_FLAG_BIT]) |
    (flags_r[`PWT_IRQ_ON_TIME_B_ENTRY_FLAG_BIT] & int_en_r[`PWT_IRQ_ON_TIME_B_ENTRY_FLAG_BIT]);
  always @(posedge clock_i) begin
    if (rst_i) begin
      snap_a_r <= `PWT_RESET_CMP;
      snap_b_r <= `PWT_RESET_CMP;
      flags_r <= `PWT_RESET_BYTE;
      scap_pend_r <= 2'h0;
    end else begin
      flags_r <= flags_nxt;
      if (cap_a) begin
        snap_a_r <= cnt_r;
      end
      if (cap_b) begin
        snap_b_r <= cnt_r;
      end
      if (wr_i && addr_i == `PWT_CMD_CTRL) begin
        scap_pend_r <= {wdata_i[`PWT_SCAP_B_BIT], wdata_i[`PWT_SCAP_A_BIT]};
      end else begin
        scap_pend_r <= 2'h0;
      end
    end
  end
  // ****************************
  // register writes
  // ****************************
  assign wr_fault_ok = wr_i && addr_i == `PWT_FAULT_CTRL && unlock_r != 3'h0;
  always @(posedge clock_i) begin
    if (por_i) begin
      fault_ctrl_r <= `PWT_RESET_BYTE;
    end else if (rst_i) begin
      fault_ctrl_r <= timer_output_fuse_i;
    end else if (wr_fault_ok) begin
      fault_ctrl_r <= wdata_i;
    end
  end
  always @(posedge clock_i) begin
    if (rst_i) begin
      ctrla_r <= `PWT_RESET_BYTE;
      ctrlc_r <= `PWT_RESET_BYTE;
      ctrld_r <= `PWT_RESET_BYTE;
      event_input_control_a_r <= `PWT_RESET_BYTE;
      event_input_control_b_r <= `PWT_RESET_BYTE;
      int_en_r <= `PWT_RESET_BYTE;
      inmode_a_r <= `PWT_RESET_BYTE;
      inmode_b_r <= `PWT_RESET_BYTE;
      dlyctrl_r <= `PWT_RESET_BYTE;
      delay_count_value_r <= `PWT_RESET_BYTE;
      ditctrl_r <= `PWT_RESET_BYTE;
      ditval_r <= `PWT_RESET_BYTE;
      aset_r <= `PWT_RESET_CMP;
      aclr_r <= `PWT_RESET_CMP;
      bset_r <= `PWT_RESET_CMP;
      bclr_r <= `PWT_RESET_CMP;
      unlock_r <= 3'h0;
    end else begin
      if (wr_i && addr_i == `PWT_PROTECT_KEY && wdata_i == `PWT_UNLOCK_KEY) begin
        unlock_r <= `PWT_UNLOCK_CYCLES;
      end else if (unlock_r != 3'h0) begin
        unlock_r <= unlock_r - 3'h1;
      end
      if (wr_i) begin
        if (addr_i == `PWT_CTRLA) begin
          ctrla_r <= wdata_i;
        end else if (addr_i == `PWT_CTRLC) begin
          ctrlc_r <= wdata_i;
        end else if (addr_i == `PWT_CTRLD) begin
          ctrld_r <= wdata_i;
        end else if (addr_i == `PWT_EVENT_INPUT_CONTROL_A) begin
          event_input_control_a_r <= wdata_i;
        end else if (addr_i == `PWT_EVENT_INPUT_CONTROL_B) begin
          event_input_control_b_r <= wdata_i;
        end else if (addr_i == `PWT_INT_EN) begin
          int_en_r <= wdata_i;
        end else if (addr_i == `PWT_INMODE_A) begin
          inmode_a_r <= {4'h0, wdata_i[3:0]};
        end else if (addr_i == `PWT_INMODE_B) begin
          inmode_b_r <= {4'h0, wdata_i[3:0]};
        end else if (addr_i == `PWT_DLYCTRL) begin
          dlyctrl_r <= {2'h0, wdata_i[5:0]};
        end else if (addr_i == `PWT_DELAY_COUNT_VALUE) begin
          delay_count_value_r <= wdata_i;
        end else if (addr_i == `PWT_DITCTRL) begin
          ditctrl_r <= {6'h00, wdata_i[1:0]};
        end else if (addr_i == `PWT_DITVAL) begin
          ditval_r <= {4'h0, wdata_i[3:0]};
        end else if (addr_i[7:1] == `PWT_ASET_L >> 1) begin
          aset_r <= wr_byte(aset_r, addr_i[0], wdata_i);
        end else if (addr_i[7:1] == `PWT_ACLR_L >> 1) begin
          aclr_r <= wr_byte(aclr_r, addr_i[0], wdata_i);
        end else if (addr_i[7:1] == `PWT_BSET_L >> 1) begin
          bset_r <= wr_byte(bset_r, addr_i[0], wdata_i);
        end else if (addr_i[7:1] == `PWT_BCLR_L >> 1) begin
          bclr_r <= wr_byte(bclr_r, addr_i[0], wdata_i);
        end
      end
    end
  end
  // ****************************
  // register reads
  // ****************************
  always @* begin
    rd_nxt = 8'h00;
    if (addr_i == `PWT_CTRLA) begin
      rd_nxt = ctrla_r;
    end else if (addr_i == `PWT_CTRLC) begin
      rd_nxt = ctrlc_r;
    end else if (addr_i == `PWT_CTRLD) begin
      rd_nxt = ctrld_r;
    end else if (addr_i == `PWT_EVENT_INPUT_CONTROL_A) begin
      rd_nxt = event_input_control_a_r;
    end else if (addr_i == `PWT_EVENT_INPUT_CONTROL_B) begin
      rd_nxt = event_input_control_b_r;
    end else if (addr_i == `PWT_INT_EN) begin
      rd_nxt = int_en_r;
    end else if (addr_i == `PWT_INT_FLAG) begin
      rd_nxt = flags_r;
    end else if (addr_i == `PWT_STATUS) begin
      rd_nxt[`PWT_COMMAND_READY_FLAG_BIT] = scap_pend_r == 2'h0;
      rd_nxt[`PWT_ENRDY_BIT] = 1'b1;
    end else if (addr_i == `PWT_INMODE_A) begin
      rd_nxt = inmode_a_r;
    end else if (addr_i == `PWT_INMODE_B) begin
      rd_nxt = inmode_b_r;
    end else if (addr_i == `PWT_FAULT_CTRL) begin
      rd_nxt = fault_ctrl_r;
    end else if (addr_i == `PWT_DLYCTRL) begin
      rd_nxt = dlyctrl_r;
    end else if (addr_i == `PWT_DELAY_COUNT_VALUE) begin
      rd_nxt = delay_count_value_r;
    end else if (addr_i == `PWT_DITCTRL) begin
      rd_nxt = ditctrl_r;
    end else if (addr_i == `PWT_DITVAL) begin
      rd_nxt = ditval_r;
    end else if (addr_i == `PWT_SNAP_A_L) begin
      rd_nxt = snap_a_r[7:0];
    end else if (addr_i == `PWT_SNAP_B_L) begin
      rd_nxt = snap_b_r[7:0];
    end else if (addr_i == `PWT_SNAP_A_H || addr_i == `PWT_SNAP_B_H) begin
      rd_nxt = {4'h0, temp_hi_r};
    end
  end
  always @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      temp_hi_r <= 4'h0;
    end else begin
      rdata_o <= rd_i ? rd_nxt : 8'h00;
      if (rd_i && addr_i == `PWT_SNAP_A_L) begin
        temp_hi_r <= snap_a_r[11:8];
      end else if (rd_i && addr_i == `PWT_SNAP_B_L) begin
        temp_hi_r <= snap_b_r[11:8];
      end
    end
  end
  // ****************************
  // waveform outputs
  // ****************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      waveform_out_a_o <= 1'b0;
      waveform_out_b_o <= 1'b0;
      waveform_out_c_o <= 1'b0;
      waveform_out_d_o <= 1'b0;
      output_enable_bits_o <= 4'h0;
    end else begin
      output_enable_bits_o <= fault_ctrl_r[7:4];
      if (fault_i || !ctrla_r[`PWT_ENABLE_BIT]) begin
        waveform_out_a_o <= fault_ctrl_r[0];
        waveform_out_b_o <= fault_ctrl_r[1];
        waveform_out_c_o <= fault_ctrl_r[2];
        waveform_out_d_o <= fault_ctrl_r[3];
      end else begin
        if (ctrlc_r[`PWT_OVR_BIT]) begin
          waveform_out_a_o <= (phase_nxt == PH_OTA) ? ctrld_r[1] : ctrld_r[0];
          waveform_out_b_o <= (phase_nxt == PH_OTB) ? ctrld_r[7] : ctrld_r[6];
        end else begin
          waveform_out_a_o <= phase_nxt == PH_OTA;
          waveform_out_b_o <= phase_nxt == PH_OTB;
        end
        waveform_out_c_o <= ctrlc_r[`PWT_CSEL_BIT] ? waveform_out_b_o : waveform_out_a_o;
        waveform_out_d_o <= ctrlc_r[`PWT_DSEL_BIT] ? waveform_out_b_o : waveform_out_a_o;
      end
    end
  end
  // ****************************
  // output events
  // ****************************
  assign prog_on_time_entry_vector = running && (
    (dlyctrl_r[1:0] == 2'h0 && cnt_r == aset_r) || (dlyctrl_r[1:0] == 2'h1 && cnt_r == aclr_r) ||
    (dlyctrl_r[1:0] == 2'h2 && cnt_r == bset_r) || (dlyctrl_r[1:0] == 2'h3 && cnt_r == bclr_r));
  assign dly_tick = pre_cnt_r == ((3'h1 << dlyctrl_r[5:4]) - 3'h1);
  always @(posedge clock_i) begin
    if (rst_i) begin
      evt_b_clear_o <= 1'b0;
      evt_a_set_o <= 1'b0;
      evt_b_set_o <= 1'b0;
      evt_prog_o <= 1'b0;
      pre_cnt_r <= 3'h0;
      dly_cnt_r <= 8'h00;
      dly_busy_r <= 1'b0;
    end else begin
      evt_b_clear_o <= running && cnt_r == bclr_r;
      evt_a_set_o <= running && cnt_r == aset_r;
      evt_b_set_o <= running && cnt_r == bset_r;
      evt_prog_o <= 1'b0;
      if (dlyctrl_r[3:2] == `PWT_DELAY_TRIGGER_SELECT_BLANK) begin
        evt_prog_o <= prog_on_time_entry_vector;
        dly_busy_r <= 1'b0;
      end else if (dlyctrl_r[3:2] == `PWT_DELAY_TRIGGER_SELECT_DELAY) begin
        if (!dly_busy_r && prog_on_time_entry_vector) begin
          if (delay_count_value_r == 8'h00) begin
            evt_prog_o <= 1'b1;
          end else begin
            dly_busy_r <= 1'b1;
            dly_cnt_r <= 8'h00;
            pre_cnt_r <= 3'h0;
          end
        end else if (dly_busy_r) begin
          pre_cnt_r <= dly_tick ? 3'h0 : pre_cnt_r + 3'h1;
          if (dly_tick) begin
            dly_cnt_r <= dly_cnt_r + 8'h01;
            if (dly_cnt_r + 8'h01 == delay_count_value_r) begin
              evt_prog_o <= 1'b1;
              dly_busy_r <= 1'b0;
            end
          end
        end
      end else begin
        dly_busy_r <= 1'b0;
      end
    end
  end
endmodule

// [verif/pwt_timer_props.sv]
// assertion checker for the pwm timer ports
`timescale 1ns/100ps
module pwt_timer_props (
  input wire clock_i,
  input wire rst_i,
  input wire por_i,
  input wire [7:0] timer_output_fuse_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire [1:0] sleep_mode_i,
  input wire sleep_i,
  input wire [3:0] output_enable_bits_o,
  input wire evt_b_clear_o,
  input wire evt_a_set_o,
  input wire evt_b_set_o,
  input wire evt_prog_o,
  input wire cycle_end_irq_o,
  input wire on_time_entry_vector_o
);
  // ****************************
  // helper logic
  // ****************************
  reg [2:0] since_key_r;
  wire stop_w = sleep_i && (sleep_mode_i != 2'h1);
  wire fc_wr_w = wr_i && (addr_i == 8'h12);
  wire irq_wr_w = wr_i && (addr_i == 8'h0C || addr_i == 8'h0D);
  always @(posedge clock_i) begin
    if (rst_i) begin
      since_key_r <= 3'h7;
    end else if (wr_i && addr_i == 8'h3F && wdata_i == 8'h5A) begin
      since_key_r <= 3'h0;
    end else if (since_key_r != 3'h7) begin
      since_key_r <= since_key_r + 3'h1;
    end
  end
  // ****************************
  // properties
  // ****************************
  default clocking cb @(posedge clock_i); endclocking
  sequence seq_asleep;
    stop_w [*2];
  endsequence
  sequence seq_por;
    por_i [*2];
  endsequence
  sequence seq_fuse;
    (rst_i && !por_i) ##1 (!rst_i && !por_i);
  endsequence
  rd_idle_zero_a: assert property (disable iff (rst_i) !$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  fault_locked_a: assert property (disable iff (rst_i || por_i)
    fc_wr_w && since_key_r > 3'h3 |=> $stable(output_enable_bits_o) [*2])
    else $error("fault control changed without unlock");
  por_clear_a: assert property (seq_por |=> output_enable_bits_o == 4'h0)
    else $error("enables not cleared by power-on reset");
  fuse_load_a: assert property (seq_fuse |=> output_enable_bits_o == timer_output_fuse_i[7:4])
    else $error("enables not loaded from fuse");
  ovf_irq_hold_a: assert property (disable iff (rst_i) cycle_end_irq_o && !irq_wr_w |=> cycle_end_irq_o)
    else $error("overflow request dropped without clear");
  on_time_entry_vector_irq_hold_a: assert property (disable iff (rst_i)
    on_time_entry_vector_o && !irq_wr_w |=> on_time_entry_vector_o)
    else $error("trigger request dropped without clear");
  sleep_stop_a: assert property (disable iff (rst_i)
    seq_asleep |-> !evt_b_clear_o && !evt_a_set_o && !evt_b_set_o)
    else $error("match strobe while stopped in sleep");
  prog_pulse_a: assert property (disable iff (rst_i) evt_prog_o |=> !evt_prog_o)
    else $error("programmable strobe longer than one cycle");
  clr_pulse_a: assert property (disable iff (rst_i) $rose(evt_b_clear_o) |=> !evt_b_clear_o)
    else $error("clear match strobe longer than one cycle");
endmodule
bind pwt_timer pwt_timer_props u_props (.clock_i(clock_i), .rst_i(rst_i), .por_i(por_i),
  .timer_output_fuse_i(timer_output_fuse_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .sleep_mode_i(sleep_mode_i), .sleep_i(sleep_i),
  .output_enable_bits_o(output_enable_bits_o), .evt_b_clear_o(evt_b_clear_o), .evt_a_set_o(evt_a_set_o),
  .evt_b_set_o(evt_b_set_o), .evt_prog_o(evt_prog_o), .cycle_end_irq_o(cycle_end_irq_o),
  .on_time_entry_vector_o(on_time_entry_vector_o));

// [verif/pwt_evt_partner.sv]
// event source and output event counter on the far side of the timer
`timescale 1ns/100ps
module pwt_evt_partner (
  input wire clock_i,
  input wire clr_i,
  input wire fire_a_i,
  input wire fire_b_i,
  input wire evt_b_clear_i,
  input wire evt_prog_i,
  output reg event_a_o,
  output reg event_b_o,
  output reg [7:0] n_clr_o,
  output reg [7:0] n_prog_o
);
  initial begin
    event_a_o = 1'b0;
    event_b_o = 1'b0;
    n_clr_o = 8'h00;
    n_prog_o = 8'h00;
  end
  // one-cycle event pulses and strobe counting
  always @(posedge clock_i) begin
    event_a_o <= fire_a_i;
    event_b_o <= fire_b_i;
    if (clr_i) begin
      n_clr_o <= 8'h00;
      n_prog_o <= 8'h00;
    end else begin
      n_clr_o <= n_clr_o + {7'h00, evt_b_clear_i};
      n_prog_o <= n_prog_o + {7'h00, evt_prog_i};
    end
  end
endmodule

// [verif/tb_top.sv]
// self-checking testbench for the pwm timer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg por_i = 1'b0;
  reg [7:0] addr_i = 8'h00;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg fault_i = 1'b0;
  reg sleep_i = 1'b0;
  reg [1:0] sleep_mode_i = 2'h1;
  reg fire_a = 1'b0;
  reg fire_b = 1'b0;
  reg clr_cnt = 1'b0;
  reg [7:0] d;
  wire [7:0] rdata_o;
  wire [3:0] oe;
  wire wa, wb, wc, wd, e_bclr, e_aset, e_bset, e_prog, irq_ovf, irq_on_time_entry_vector, ev_a, ev_b;
  wire [7:0] n_clr, n_prog;
  int n_fail = 0;
  int n_compared = 0;
  always #10 clock_i = ~clock_i;
  pwt_timer dut (.clock_i(clock_i), .rst_i(rst_i), .por_i(por_i), .timer_output_fuse_i(8'hA3),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_a_i(ev_a),
    .event_b_i(ev_b), .fault_i(fault_i), .sleep_mode_i(sleep_mode_i), .sleep_i(sleep_i),
    .waveform_out_a_o(wa), .waveform_out_b_o(wb), .waveform_out_c_o(wc), .waveform_out_d_o(wd),
    .output_enable_bits_o(oe), .evt_b_clear_o(e_bclr), .evt_a_set_o(e_aset), .evt_b_set_o(e_bset),
    .evt_prog_o(e_prog), .cycle_end_irq_o(irq_ovf), .on_time_entry_vector_o(irq_on_time_entry_vector));
  pwt_evt_partner u_far (.clock_i(clock_i), .clr_i(clr_cnt), .fire_a_i(fire_a), .fire_b_i(fire_b),
    .evt_b_clear_i(e_bclr), .evt_prog_i(e_prog), .event_a_o(ev_a), .event_b_o(ev_b),
    .n_clr_o(n_clr), .n_prog_o(n_prog));
  // ****************************
  // bus and helper tasks
  // ****************************
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task fire(input bit b);
    @(posedge clock_i);
    fire_a <= !b;
    fire_b <= b;
    @(posedge clock_i);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
  endtask
  task cnt;
    cyc(2);
    @(posedge clock_i);
    clr_cnt <= 1'b1;
    @(posedge clock_i);
    clr_cnt <= 1'b0;
    cyc(128);
  endtask
  task wait_on(input bit which, output int n);
    n = 0;
    while ((which ? e_prog : e_bclr) !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n == 100) n_fail++;
  endtask
  task meas(input [7:0] c, input [7:0] v, output int n);
    int i;
    wr(8'h14, c);
    wr(8'h15, v);
    cyc(40);
    wait_on(1'b0, i);
    wait_on(1'b1, n);
  endtask
  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****************************
  // scenarios
  // ****************************
  task t_fault_ctrl;
    rd(8'h12);
    `CHK("fuse load", 8'hA3, d)
    `CHK("enables", 4'hA, oe)
    wr(8'h12, 8'hF5);
    rd(8'h12);
    `CHK("locked write", 8'hA3, d)
    wr(8'h3F, 8'h5A);
    wr(8'h12, 8'hF5);
    rd(8'h12);
    `CHK("unlocked write", 8'hF5, d)
    `CHK("enables on", 4'hF, oe)
    wr(8'h3F, 8'h5A);
    cyc(5);
    wr(8'h12, 8'h00);
    rd(8'h12);
    `CHK("late write", 8'hF5, d)
    rd(8'h05);
    `CHK("unmapped read", 8'h00, d)
  endtask
  task t_route;
    wr(8'h03, 8'hC0);
    wr(8'h02, 8'h41);
    cyc(40);
    `CHK("c from b", 4'h6, {wd, wc, wb, wa})
    wr(8'h02, 8'h81);
    cyc(40);
    `CHK("c from a", 4'hA, {wd, wc, wb, wa})
    @(posedge clock_i);
    fault_i <= 1'b1;
    cyc(4);
    `CHK("fault levels", 4'h5, {wd, wc, wb, wa})
    @(posedge clock_i);
    fault_i <= 1'b0;
    wr(8'h03, 8'h03);
    cyc(4);
    `CHK("matched levels", 4'h5, {wd, wc, wb, wa})
  endtask
  task t_evt_capture;
    wr(8'h00, 8'h00);
    wr(8'h0D, 8'hFF);
    wr(8'h0C, 8'h0C);
    wr(8'h08, 8'h04);
    wr(8'h09, 8'h00);
    fire(1'b1);
    cyc(4);
    rd(8'h0D);
    `CHK("no action", 8'h00, d)
    `CHK("vector idle", 1'b0, irq_on_time_entry_vector)
    fire(1'b0);
    cyc(4);
    rd(8'h0D);
    `CHK("capture flag", 8'h04, d)
    `CHK("vector on", 1'b1, irq_on_time_entry_vector)
    wr(8'h0D, 8'h04);
    cyc(2);
    `CHK("vector cleared", 1'b0, irq_on_time_entry_vector)
  endtask
  task t_soft;
    reg [11:0] a, b;
    wr(8'h00, 8'h01);
    cyc(10);
    wr(8'h04, 8'h08);
    wr(8'h04, 8'h10);
    cyc(2);
    rd(8'h0E);
    `CHK("cmd ready", 8'h02, d & 8'h02)
    rd(8'h22);
    a[7:0] = d;
    rd(8'h23);
    a[11:8] = d[3:0];
    rd(8'h24);
    b[7:0] = d;
    rd(8'h25);
    b[11:8] = d[3:0];
    `CHK("snap spacing", 12'h002, (b - a) & 12'h01F)
  endtask
  task t_ovf;
    wr(8'h0D, 8'hFF);
    wr(8'h0C, 8'h01);
    cyc(40);
    `CHK("ovf request", 1'b1, irq_ovf)
    wr(8'h0C, 8'h00);
    cyc(1);
    `CHK("ovf masked", 1'b0, irq_ovf)
  endtask
  task t_events;
    wr(8'h14, 8'h07);
    cnt;
    `CHK("clear strobes", 8'h04, n_clr)
    `CHK("prog strobes", 8'h04, n_prog)
    @(posedge clock_i);
    sleep_mode_i <= 2'h2;
    sleep_i <= 1'b1;
    cnt;
    `CHK("standby strobes", 8'h00, n_clr)
    @(posedge clock_i);
    sleep_mode_i <= 2'h1;
    cnt;
    `CHK("idle strobes", 8'h04, n_clr)
    @(posedge clock_i);
    sleep_i <= 1'b0;
  endtask
  task t_delay;
    int d0, d4, d8;
    meas(8'h0B, 8'h00, d0);
    meas(8'h0B, 8'h04, d4);
    meas(8'h1B, 8'h04, d8);
    `CHK("delay four", 32'h4, d4 - d0)
    `CHK("delay prescaled", 32'h8, d8 - d0)
  endtask
  task t_end_on;
    int n;
    wr(8'h09, 8'h04);
    wr(8'h11, 8'h08);
    n = 0;
    while (e_bset !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n == 100) n_fail++;
    fire(1'b1);
    n = 0;
    while (e_aset !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n == 100) n_fail++;
    rd(8'h24);
    `CHK("early restart", 1'b1, n < 9)
    `CHK("snap in on-time b", 1'b1, d >= 8'h14)
  endtask
  task t_dither;
    int n;
    wr(8'h02, 8'h00);
    wr(8'h18, 8'h02);
    wr(8'h19, 8'h08);
    cyc(100);
    n = 0;
    repeat (128) begin
      cyc(1);
      n = n + wb;
    end
    `CHK("on-time b shortened", 46, n)
  endtask
  task t_por;
    @(posedge clock_i);
    por_i <= 1'b1;
    cyc(3);
    @(posedge clock_i);
    por_i <= 1'b0;
    rd(8'h12);
    `CHK("por clear", 8'h00, d)
  endtask
  // ****************************
  // main sequence and watchdog
  // ****************************
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    t_fault_ctrl;
    wr(8'h28, 8'h04);
    wr(8'h2A, 8'h0C);
    wr(8'h2C, 8'h14);
    wr(8'h2E, 8'h1F);
    wr(8'h00, 8'h01);
    t_route;
    t_evt_capture;
    t_soft;
    t_ovf;
    t_events;
    t_delay;
    t_end_on;
    t_dither;
    t_por;
    report_and_stop;
  end
  initial begin
    repeat (6000) @(posedge clock_i);
    n_fail++;
    report_and_stop;
  end
endmodule
